/* File: core/cdcp_pkg.sv */
// constants and types for the curve and display command parser
package cdcp_pkg;
	// register byte addresses
	localparam logic [7:0] A_CMD  = 8'h00;
	localparam logic [7:0] A_ARG0 = 8'h04;
	localparam logic [7:0] A_ARG1 = 8'h08;
	localparam logic [7:0] A_ARG2 = 8'h0C;
	localparam logic [7:0] A_STAT = 8'h10;
	localparam logic [7:0] A_REP0 = 8'h14;
	localparam logic [7:0] A_REP1 = 8'h18;
	localparam logic [7:0] A_EXC  = 8'h1C;
	localparam logic [7:0] A_TYPE = 8'h20;
	// status bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_OK   = 1;
	localparam int ST_REJ  = 2;
	// curve storage
	localparam int VW      = 24;
	localparam int PTS     = 200;
	localparam int UCURVES = 39;
	localparam int DEPTH   = UCURVES * PTS;
	localparam int AW      = 13;
	localparam logic [7:0] CRV_LO = 8'h01;
	localparam logic [7:0] USR_LO = 8'h15;
	localparam logic [7:0] CRV_HI = 8'h3B;
	localparam logic [7:0] IDX_LO = 8'h01;
	localparam logic [7:0] IDX_HI = 8'hC8;
	// command arguments
	localparam logic [7:0] RESTORE_KEY = 8'h63;
	localparam logic [7:0] EXT_LO      = 8'h02;
	localparam logic [7:0] EXT_HI      = 8'h05;
	localparam logic [7:0] EXC_HI      = 8'h01;
	localparam logic [7:0] FLD_LO      = 8'h01;
	localparam logic [7:0] FLD_HI      = 8'h08;
	localparam logic [7:0] ITEM_HI     = 8'h08;
	localparam logic [7:0] UNITS_LO    = 8'h01;
	localparam logic [7:0] UNITS_HI    = 8'h05;
	localparam logic [7:0] INP_LO      = 8'h01;
	localparam logic [7:0] INP_HI      = 8'h08;
	localparam logic [7:0] INP_EXT     = 8'h05;
	localparam logic [7:0] TYPE_HI     = 8'h04;
	localparam logic [3:0] TYPE_DIODE  = 4'h1;
	// values after reset and factory restore
	localparam logic [3:0] TYPE_RST  = 4'h1;
	localparam logic [3:0] EXC_RST   = 4'h0;
	localparam logic [3:0] ITEM_RST  = 4'h0;
	localparam logic [2:0] UNITS_RST = 3'h1;
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		OP_NONE, OP_CPW, OP_CPQ, OP_FR, OP_DES, OP_CFS, OP_CFQ, OP_STS
	} cdcp_op_t;

	typedef enum logic [1:0] {S_IDLE, S_EXEC, S_QRD} cdcp_fsm_t;
endpackage

/* File: core/cdcp_curve_store.sv */
// flip-flop storage of user calibration curve points
`timescale 1ns/1ps
`default_nettype none
module cdcp_curve_store (
	// clock and reset
	input  wire logic                             i_mclk,
	input  wire logic                             i_srst,
	// write port
	input  wire logic                             i_we,
	input  wire logic [cdcp_pkg::AW-1:0]          i_waddr,
	input  wire logic [2*cdcp_pkg::VW-1:0]        i_wdata,
	// read port, data one cycle after address
	input  wire logic [cdcp_pkg::AW-1:0]          i_raddr,
	output logic      [2*cdcp_pkg::VW-1:0]        o_rdata
);
	typedef struct packed {
		logic [cdcp_pkg::DEPTH-1:0][2*cdcp_pkg::VW-1:0] mem;
		logic [2*cdcp_pkg::VW-1:0]                      rd;
	} cdcp_cs_t;

	cdcp_cs_t st;
	cdcp_cs_t next_st;

	always_comb begin
		next_st = st;
		next_st.rd = st.mem[i_raddr];
		if (i_we) begin
			next_st.mem[i_waddr] = i_wdata;
		end
		// point contents are data, only the read register is cleared
		if (i_srst) begin
			next_st.rd = '0;
		end
	end

	always_ff @(posedge i_mclk) begin
		st <= next_st;
	end

	assign o_rdata = st.rd;
endmodule
`default_nettype wire

/* File: core/cdcp_cmd_parser.sv */
// command parser for curve points, defaults, diode excitation and display fields
// ==========================================================================
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module cdcp_cmd_parser (
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_srst,
	// axi4-lite write address and data
	input  wire logic        i_axi_awvalid,
	output logic             o_axi_awready,
	input  wire logic [7:0]  i_axi_awaddr,
	input  wire logic        i_axi_wvalid,
	output logic             o_axi_wready,
	input  wire logic [31:0] i_axi_wdata,
	input  wire logic [3:0]  i_axi_wstrb,
	// axi4-lite write response
	output logic             o_axi_bvalid,
	input  wire logic        i_axi_bready,
	output logic [1:0]       o_axi_bresp,
	// axi4-lite read
	input  wire logic        i_axi_arvalid,
	output logic             o_axi_arready,
	input  wire logic [7:0]  i_axi_araddr,
	output logic             o_axi_rvalid,
	input  wire logic        i_axi_rready,
	output logic [31:0]      o_axi_rdata,
	output logic [1:0]       o_axi_rresp,
	// display side
	input  wire logic        i_custom_mode,
	input  wire logic [23:0] i_pref_units,
	output logic [31:0]      o_field_item,
	output logic [23:0]      o_field_units,
	// input configuration
	output logic [3:0]       o_diode_exc,
	output logic [31:0]      o_sensor_type,
	output logic             o_instr_reset
);
	typedef struct packed {
		logic                         aw_h;
		logic [7:0]                   aw_a;
		logic                         w_h;
		logic [31:0]                  w_d;
		logic [3:0]                   w_s;
		logic                         bvalid;
		logic [1:0]                   bresp;
		logic                         rvalid;
		logic [31:0]                  rdata;
		logic [1:0]                   rresp;
		logic [31:0]                  arg0;
		logic [31:0]                  arg1;
		logic [31:0]                  arg2;
		cdcp_pkg::cdcp_op_t           op;
		cdcp_pkg::cdcp_fsm_t          fsm;
		logic                         last_ok;
		logic                         last_rej;
		logic                         qstd;
		logic [31:0]                  rep0;
		logic [31:0]                  rep1;
		logic [7:0][3:0]              types;
		logic [3:0]                   exc;
		logic [7:0][3:0]              items;
		logic [7:0][2:0]              units;
		logic [7:0][3:0]              d_item;
		logic [7:0][2:0]              d_units;
		logic                         cwe;
		logic [cdcp_pkg::AW-1:0]      caddr;
		logic [2*cdcp_pkg::VW-1:0]    cwd;
		logic                         irst;
	} cdcp_st_t;

	cdcp_st_t st;
	cdcp_st_t next_st;

	logic [7:0]                b0;
	logic [7:0]                b1;
	logic [7:0]                b2;
	logic                      exec;
	logic                      cpw_ok;
	logic                      cpq_ok;
	logic                      des_ok;
	logic                      is_diode;
	logic                      cfs_ok;
	logic                      cfq_ok;
	logic                      sts_ok;
	logic                      cmd_ok;
	logic [1:0]                exi;
	logic [2:0]                fi;
	logic [2:0]                ti;
	logic [cdcp_pkg::AW-1:0]   pt_addr;
	logic [2*cdcp_pkg::VW-1:0] rd;
	logic [31:0]               ext_u;
	logic [31:0]               ext_t;
	logic                      do_wr;

	// ======================================================================
	// argument decode and range checks
	assign b0   = st.arg0[7:0];
	assign b1   = st.arg0[15:8];
	assign b2   = st.arg0[23:16];
	assign exec = (st.fsm == cdcp_pkg::S_EXEC);
	assign exi  = 2'(b0 - cdcp_pkg::EXT_LO);
	assign fi   = 3'(b0 - cdcp_pkg::FLD_LO);
	assign ti   = 3'(b0 - cdcp_pkg::INP_LO);
	assign pt_addr = cdcp_pkg::AW'((int'(b0) - int'(cdcp_pkg::USR_LO)) * cdcp_pkg::PTS
		+ int'(b1) - int'(cdcp_pkg::IDX_LO));
	assign cpw_ok = (b0 >= cdcp_pkg::USR_LO) && (b0 <= cdcp_pkg::CRV_HI)
		&& (b1 >= cdcp_pkg::IDX_LO) && (b1 <= cdcp_pkg::IDX_HI);
	assign cpq_ok = (b0 >= cdcp_pkg::CRV_LO) && (b0 <= cdcp_pkg::CRV_HI)
		&& (b1 >= cdcp_pkg::IDX_LO) && (b1 <= cdcp_pkg::IDX_HI);
	// extended input 2..5 sits at sensor slot 4..7
	assign is_diode = (st.types[3'(exi + 2'h0) + 3'h4] == cdcp_pkg::TYPE_DIODE);
	assign des_ok = (b0 >= cdcp_pkg::EXT_LO) && (b0 <= cdcp_pkg::EXT_HI)
		&& (b1 <= cdcp_pkg::EXC_HI) && is_diode;
	assign cfs_ok = (b0 >= cdcp_pkg::FLD_LO) && (b0 <= cdcp_pkg::FLD_HI)
		&& (b1 <= cdcp_pkg::ITEM_HI)
		&& (b2 >= cdcp_pkg::UNITS_LO) && (b2 <= cdcp_pkg::UNITS_HI);
	assign cfq_ok = (b0 >= cdcp_pkg::FLD_LO) && (b0 <= cdcp_pkg::FLD_HI);
	assign sts_ok = (b0 >= cdcp_pkg::INP_LO) && (b0 <= cdcp_pkg::INP_HI)
		&& (b1 <= cdcp_pkg::TYPE_HI);

	always_comb begin
		unique case (st.op)
			cdcp_pkg::OP_CPW: cmd_ok = cpw_ok;
			cdcp_pkg::OP_CPQ: cmd_ok = cpq_ok;
			cdcp_pkg::OP_FR:  cmd_ok = (b0 == cdcp_pkg::RESTORE_KEY);
			cdcp_pkg::OP_DES: cmd_ok = des_ok;
			cdcp_pkg::OP_CFS: cmd_ok = cfs_ok;
			cdcp_pkg::OP_CFQ: cmd_ok = cfq_ok;
			cdcp_pkg::OP_STS: cmd_ok = sts_ok;
			cdcp_pkg::OP_NONE: cmd_ok = 1'b0;
		endcase
	end

	// sign-extended point halves from the store
	assign ext_u = {{(32-cdcp_pkg::VW){rd[2*cdcp_pkg::VW-1]}}, rd[2*cdcp_pkg::VW-1:cdcp_pkg::VW]};
	assign ext_t = {{(32-cdcp_pkg::VW){rd[cdcp_pkg::VW-1]}}, rd[cdcp_pkg::VW-1:0]};

	// read address straight from the arguments, so the point is latched during exec
	cdcp_curve_store u_store (
		.i_mclk  (i_mclk),
		.i_srst  (i_srst),
		.i_we    (st.cwe),
		.i_waddr (st.caddr),
		.i_wdata (st.cwd),
		.i_raddr (pt_addr),
		.o_rdata (rd)
	);

	// ======================================================================
	// bus slave, command execution and display selection
	assign o_axi_awready = !st.aw_h;
	assign o_axi_wready  = !st.w_h;
	assign o_axi_arready = !st.rvalid;
	assign do_wr = st.aw_h && st.w_h && !st.bvalid;

	always_comb begin
		next_st = st;
		next_st.cwe  = 1'b0;
		next_st.irst = 1'b0;
		if (i_axi_awvalid && !st.aw_h) begin
			next_st.aw_h = 1'b1;
			next_st.aw_a = i_axi_awaddr;
		end
		if (i_axi_wvalid && !st.w_h) begin
			next_st.w_h = 1'b1;
			next_st.w_d = i_axi_wdata;
			next_st.w_s = i_axi_wstrb;
		end
		if (st.bvalid && i_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (do_wr) begin
			next_st.aw_h   = 1'b0;
			next_st.w_h    = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp  = cdcp_pkg::RESP_OKAY;
			for (int k = 0; k < 4; k++) begin
				if (st.w_s[k]) begin
					if (st.aw_a == cdcp_pkg::A_ARG0) next_st.arg0[k*8+:8] = st.w_d[k*8+:8];
					if (st.aw_a == cdcp_pkg::A_ARG1) next_st.arg1[k*8+:8] = st.w_d[k*8+:8];
					if (st.aw_a == cdcp_pkg::A_ARG2) next_st.arg2[k*8+:8] = st.w_d[k*8+:8];
				end
			end
			unique case (st.aw_a)
				cdcp_pkg::A_CMD: begin
					// a command while busy is dropped
					if (st.fsm == cdcp_pkg::S_IDLE && st.w_s[0]) begin
						next_st.op  = cdcp_pkg::cdcp_op_t'(st.w_d[2:0]);
						next_st.fsm = cdcp_pkg::S_EXEC;
					end
				end
				cdcp_pkg::A_ARG0, cdcp_pkg::A_ARG1, cdcp_pkg::A_ARG2,
				cdcp_pkg::A_STAT, cdcp_pkg::A_REP0, cdcp_pkg::A_REP1,
				cdcp_pkg::A_EXC, cdcp_pkg::A_TYPE: begin
				end
				default: next_st.bresp = cdcp_pkg::RESP_SLVERR;
			endcase
		end
		if (st.rvalid && i_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (i_axi_arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = cdcp_pkg::RESP_OKAY;
			unique case (i_axi_araddr)
				cdcp_pkg::A_CMD:  next_st.rdata = {29'h0, st.op};
				cdcp_pkg::A_ARG0: next_st.rdata = st.arg0;
				cdcp_pkg::A_ARG1: next_st.rdata = st.arg1;
				cdcp_pkg::A_ARG2: next_st.rdata = st.arg2;
				cdcp_pkg::A_STAT: next_st.rdata = {29'h0, st.last_rej, st.last_ok,
					st.fsm != cdcp_pkg::S_IDLE};
				cdcp_pkg::A_REP0: next_st.rdata = st.rep0;
				cdcp_pkg::A_REP1: next_st.rdata = st.rep1;
				cdcp_pkg::A_EXC:  next_st.rdata = {28'h0, st.exc};
				cdcp_pkg::A_TYPE: next_st.rdata = st.types;
				default: begin
					next_st.rdata = 32'h0;
					next_st.rresp = cdcp_pkg::RESP_SLVERR;
				end
			endcase
		end
		unique case (st.fsm)
			cdcp_pkg::S_IDLE: begin
			end
			cdcp_pkg::S_EXEC: begin
				next_st.last_ok  = cmd_ok;
				next_st.last_rej = !cmd_ok;
				next_st.fsm      = cdcp_pkg::S_IDLE;
				// nothing below changes unless its check passed
				if (cmd_ok) begin
					unique case (st.op)
						cdcp_pkg::OP_CPW: begin
							next_st.cwe   = 1'b1;
							next_st.caddr = pt_addr;
							next_st.cwd   = {st.arg1[cdcp_pkg::VW-1:0], st.arg2[cdcp_pkg::VW-1:0]};
						end
						cdcp_pkg::OP_CPQ: begin
							next_st.caddr = pt_addr;
							next_st.qstd  = (b0 < cdcp_pkg::USR_LO);
							next_st.fsm   = cdcp_pkg::S_QRD;
						end
						cdcp_pkg::OP_FR: begin
							next_st.types = {8{cdcp_pkg::TYPE_RST}};
							next_st.exc   = cdcp_pkg::EXC_RST;
							next_st.items = {8{cdcp_pkg::ITEM_RST}};
							next_st.units = {8{cdcp_pkg::UNITS_RST}};
							next_st.irst  = 1'b1;
						end
						cdcp_pkg::OP_DES: next_st.exc[exi] = b1[0];
						cdcp_pkg::OP_CFS: begin
							next_st.items[fi] = b1[3:0];
							next_st.units[fi] = b2[2:0];
						end
						cdcp_pkg::OP_CFQ: begin
							next_st.rep0 = {28'h0, st.items[fi]};
							next_st.rep1 = {29'h0, st.units[fi]};
						end
						cdcp_pkg::OP_STS: begin
							next_st.types[ti] = b1[3:0];
							if (b0 >= cdcp_pkg::INP_EXT) begin
								next_st.exc[2'(b0 - cdcp_pkg::INP_EXT)] = 1'b0;
							end
						end
						cdcp_pkg::OP_NONE: begin
						end
					endcase
				end
			end
			cdcp_pkg::S_QRD: begin
				// standard curves hold no table here and read as zero
				next_st.rep0 = st.qstd ? 32'h0 : ext_u;
				next_st.rep1 = st.qstd ? 32'h0 : ext_t;
				next_st.fsm  = cdcp_pkg::S_IDLE;
			end
		endcase
		for (int k = 0; k < 8; k++) begin
			next_st.d_item[k]  = i_custom_mode ? st.items[k] : 4'(k + 1);
			next_st.d_units[k] = i_custom_mode ? st.units[k] : i_pref_units[k*3+:3];
		end
		if (i_srst) begin
			next_st       = '0;
			next_st.op    = cdcp_pkg::OP_NONE;
			next_st.fsm   = cdcp_pkg::S_IDLE;
			next_st.types = {8{cdcp_pkg::TYPE_RST}};
			next_st.exc   = cdcp_pkg::EXC_RST;
			next_st.items = {8{cdcp_pkg::ITEM_RST}};
			next_st.units = {8{cdcp_pkg::UNITS_RST}};
		end
	end

	always_ff @(posedge i_mclk) begin
		st <= next_st;
	end

	assign o_axi_bvalid  = st.bvalid;
	assign o_axi_bresp   = st.bresp;
	assign o_axi_rvalid  = st.rvalid;
	assign o_axi_rdata   = st.rdata;
	assign o_axi_rresp   = st.rresp;
	assign o_field_item  = st.d_item;
	assign o_field_units = st.d_units;
	assign o_diode_exc   = st.exc;
	assign o_sensor_type = st.types;
	assign o_instr_reset = st.irst;

	// ======================================================================
	// checks
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_srst);

	sequence s_cmd(cdcp_pkg::cdcp_op_t o);
		exec && st.op == o;
	endsequence
	sequence s_qread;
		st.fsm == cdcp_pkg::S_QRD ##1 st.fsm == cdcp_pkg::S_IDLE;
	endsequence

	AST_CPW_STORE: assert property (s_cmd(cdcp_pkg::OP_CPW) ##0 cpw_ok |=> st.cwe && st.caddr == $past(pt_addr))
		else $error("valid point write not stored");
	AST_CPW_REJ: assert property (s_cmd(cdcp_pkg::OP_CPW) ##0 !cpw_ok |=> !st.cwe)
		else $error("out-of-range point write stored");
	AST_CPW_DATA: assert property (st.cwe |-> st.cwd == {$past(st.arg1[23:0]), $past(st.arg2[23:0])})
		else $error("point data not units then kelvin");
	AST_CPQ_REPLY: assert property (s_cmd(cdcp_pkg::OP_CPQ) ##0 cpq_ok ##0 b0 >= cdcp_pkg::USR_LO
		|=> s_qread ##0 st.rep0 == $past(ext_u) && st.rep1 == $past(ext_t))
		else $error("point query reply wrong");
	AST_FR_KEY: assert property (s_cmd(cdcp_pkg::OP_FR) ##0 b0 != cdcp_pkg::RESTORE_KEY
		|=> !o_instr_reset && $stable(st.items) && $stable(st.types))
		else $error("restore acted without key");
	AST_FR_DO: assert property (s_cmd(cdcp_pkg::OP_FR) ##0 b0 == cdcp_pkg::RESTORE_KEY
		|=> o_instr_reset && st.exc == 4'h0 && st.units[7] == 3'h1 ##1 !o_instr_reset)
		else $error("restore did not restore");
	AST_DES_SET: assert property (s_cmd(cdcp_pkg::OP_DES) ##0 des_ok |=> st.exc[$past(exi)] == $past(b1[0]))
		else $error("excitation not applied");
	AST_DES_IGN: assert property (s_cmd(cdcp_pkg::OP_DES) ##0 !is_diode |=> $stable(st.exc))
		else $error("excitation changed on non-diode input");
	AST_STS_EXC: assert property (s_cmd(cdcp_pkg::OP_STS) ##0 sts_ok ##0 b0 >= cdcp_pkg::INP_EXT
		|=> st.exc[$past(2'(b0 - cdcp_pkg::INP_EXT))] == 1'b0)
		else $error("type change kept high excitation");
	AST_CFS_SET: assert property (s_cmd(cdcp_pkg::OP_CFS) ##0 cfs_ok
		|=> st.items[$past(fi)] == $past(b1[3:0]) && st.units[$past(fi)] == $past(b2[2:0]))
		else $error("field not stored");
	AST_UNITS_CODE: assert property (st.units[$past(fi)] >= 3'h1 && st.units[$past(fi)] <= 3'h5)
		else $error("units code out of range");
	AST_FIXED_MODE: assert property (!i_custom_mode |=> o_field_units == $past(i_pref_units)
		&& o_field_item == 32'h87654321)
		else $error("fixed display not shown");
	AST_CFQ_REPLY: assert property (s_cmd(cdcp_pkg::OP_CFQ) ##0 cfq_ok
		|=> st.rep0 == {28'h0, $past(st.items[fi])} && st.rep1 == {29'h0, $past(st.units[fi])})
		else $error("field query reply wrong");
	AST_REJ_HOLD: assert property (exec && !cmd_ok
		|=> $stable(st.types) && $stable(st.exc) && $stable(st.items) && $stable(st.units) && st.last_rej)
		else $error("rejected command changed configuration");
endmodule
`default_nettype wire

/* File: sim/cdcp_host_model.sv */
// host-side axi4-lite master model for the command parser
`timescale 1ns/1ps
`default_nettype none
module cdcp_host_model (
	// clock
	input  wire logic        i_mclk,
	// write address, data and response
	output logic             o_awvalid,
	input  wire logic        i_awready,
	output logic [7:0]       o_awaddr,
	output logic             o_wvalid,
	input  wire logic        i_wready,
	output logic [31:0]      o_wdata,
	output logic [3:0]       o_wstrb,
	input  wire logic        i_bvalid,
	output logic             o_bready,
	// read address and data
	output logic             o_arvalid,
	input  wire logic        i_arready,
	output logic [7:0]       o_araddr,
	input  wire logic        i_rvalid,
	output logic             o_rready,
	input  wire logic [31:0] i_rdata
);
	initial begin
		o_awvalid = 1'b0;
		o_awaddr  = 8'h00;
		o_wvalid  = 1'b0;
		o_wdata   = 32'h00000000;
		o_wstrb   = 4'hF;
		o_bready  = 1'b0;
		o_arvalid = 1'b0;
		o_araddr  = 8'h00;
		o_rready  = 1'b0;
	end
	// address and data offered together, each released when taken
	task automatic write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		logic aw_pend;
		logic w_pend;
		aw_pend = 1'b1;
		w_pend  = 1'b1;
		@(posedge i_mclk);
		o_awvalid <= 1'b1;
		o_awaddr  <= a;
		o_wvalid  <= 1'b1;
		o_wdata   <= d;
		o_wstrb   <= s;
		o_bready  <= 1'b1;
		while (aw_pend || w_pend) begin
			@(posedge i_mclk);
			if (aw_pend && i_awready) begin
				aw_pend = 1'b0;
				o_awvalid <= 1'b0;
				o_awaddr  <= ~a;
			end
			if (w_pend && i_wready) begin
				w_pend = 1'b0;
				o_wvalid <= 1'b0;
				o_wdata  <= ~d;
			end
		end
		do @(posedge i_mclk); while (!i_bvalid);
		o_bready <= 1'b0;
	endtask
	task automatic read(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_mclk);
		o_arvalid <= 1'b1;
		o_araddr  <= a;
		o_rready  <= 1'b1;
		do @(posedge i_mclk); while (!i_arready);
		o_arvalid <= 1'b0;
		o_araddr  <= ~a;
		do @(posedge i_mclk); while (!i_rvalid);
		d = i_rdata;
		o_rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: sim/cdcp_cmd_parser_test.sv */
// self-checking bench for the command parser
`timescale 1ns/1ps
`default_nettype none
module cdcp_cmd_parser_test;
	typedef struct packed {logic chk; logic [1:0] resp; logic [31:0] data;} cdcp_exp_t;
	localparam logic [1:0] OK = cdcp_pkg::RESP_OKAY;
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic        custom_mode = 1'b1;
	logic [23:0] pref_units = 24'h000000;
	wire logic   awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, instr_reset;
	wire logic [7:0]  awaddr, araddr;
	wire logic [31:0] wdata, rdata, field_item, sensor_type;
	wire logic [3:0]  wstrb, diode_exc;
	wire logic [1:0]  bresp, rresp;
	wire logic [23:0] field_units;
	int          fail_count = 0;
	int          check_count = 0;
	int          pulses = 0;
	cdcp_exp_t   exp_q[$];
	logic [1:0]  expb_q[$];
	logic [31:0] rv;
	always #50 mclk = ~mclk;
	cdcp_cmd_parser dut_u (.i_mclk(mclk), .i_srst(srst), .i_axi_awvalid(awvalid), .o_axi_awready(awready),
		.i_axi_awaddr(awaddr), .i_axi_wvalid(wvalid), .o_axi_wready(wready), .i_axi_wdata(wdata),
		.i_axi_wstrb(wstrb), .o_axi_bvalid(bvalid), .i_axi_bready(bready), .o_axi_bresp(bresp),
		.i_axi_arvalid(arvalid), .o_axi_arready(arready), .i_axi_araddr(araddr), .o_axi_rvalid(rvalid),
		.i_axi_rready(rready), .o_axi_rdata(rdata), .o_axi_rresp(rresp), .i_custom_mode(custom_mode),
		.i_pref_units(pref_units), .o_field_item(field_item), .o_field_units(field_units),
		.o_diode_exc(diode_exc), .o_sensor_type(sensor_type), .o_instr_reset(instr_reset));
	cdcp_host_model host_u (.i_mclk(mclk), .o_awvalid(awvalid), .i_awready(awready), .o_awaddr(awaddr),
		.o_wvalid(wvalid), .i_wready(wready), .o_wdata(wdata), .o_wstrb(wstrb), .i_bvalid(bvalid),
		.o_bready(bready), .o_arvalid(arvalid), .i_arready(arready), .o_araddr(araddr), .i_rvalid(rvalid),
		.o_rready(rready), .i_rdata(rdata));
	task automatic cmp(input logic [33:0] got, input logic [33:0] want);
		check_count++;
		if (got !== want) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// =====================================================
	// result watcher
	always @(posedge mclk) begin
		cdcp_exp_t e;
		if (rvalid === 1'b1 && rready) begin
			e = exp_q.pop_front();
			if (e.chk) cmp({rresp, rdata}, {e.resp, e.data});
		end
		if (bvalid === 1'b1 && bready) cmp(34'(bresp), 34'(expb_q.pop_front()));
		if (instr_reset === 1'b1) pulses++;
	end
	initial begin
		repeat (30000) @(posedge mclk);
		fail_count++;
		results();
	end
	// =====================================================
	// bus and command helpers
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r, input logic [3:0] s = 4'hF);
		expb_q.push_back(r);
		host_u.write(a, d, s);
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] want);
		exp_q.push_back({1'b1, want});
		host_u.read(a, rv);
	endtask
	// st: 0 accepted, 1 rejected, 2 not checked
	task automatic cmd(input logic [2:0] op, input logic [31:0] a0, input logic [31:0] a1,
			input logic [31:0] a2, input int st);
		wr(cdcp_pkg::A_ARG0, a0, OK);
		wr(cdcp_pkg::A_ARG1, a1, OK);
		wr(cdcp_pkg::A_ARG2, a2, OK);
		wr(cdcp_pkg::A_CMD, {29'h0, op}, OK);
		do begin
			exp_q.push_back('0);
			host_u.read(cdcp_pkg::A_STAT, rv);
		end while (rv[cdcp_pkg::ST_BUSY] !== 1'b0);
		if (st < 2) cmp(34'(rv), {31'h0, st == 1, st == 0, 1'b0});
	endtask
	// =====================================================
	// tests
	initial begin
		int c, ix, u, t, u0, t0, k, f, un;
		logic [31:0] ei;
		logic [23:0] eu;
		logic [15:0] bad[4] = '{16'h0114, 16'h013C, 16'h0015, 16'hC915};
		logic [23:0] badf[5] = '{24'h010100, 24'h010109, 24'h010901, 24'h000101, 24'h060101};
		void'($urandom(54621));
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		@(negedge mclk);
		cmp(34'(diode_exc), 34'(cdcp_pkg::EXC_RST));
		cmp(34'(field_units), 34'h249249);
		rd(cdcp_pkg::A_TYPE, {OK, 32'h11111111});
		rd(8'h24, {cdcp_pkg::RESP_SLVERR, 32'h0});
		wr(cdcp_pkg::A_EXC, 32'hF, OK);
		wr(8'h40, 32'h0, cdcp_pkg::RESP_SLVERR);
		rd(cdcp_pkg::A_EXC, {OK, 32'h0});
		wr(cdcp_pkg::A_ARG0, 32'hFFFFFFFF, OK);
		wr(cdcp_pkg::A_ARG0, 32'h12345678, OK, 4'h5);
		rd(cdcp_pkg::A_ARG0, {OK, 32'hFF34FF78});
		wr(cdcp_pkg::A_CMD, 32'h1, OK, 4'hE);
		rd(cdcp_pkg::A_CMD, {OK, 32'h0});
		$display("test bus_map done");
		for (k = 0; k < 3; k++) begin
			c = (k == 0) ? 21 : (k == 1) ? 59 : $urandom_range(58, 22);
			ix = (k == 0) ? 1 : (k == 1) ? 200 : $urandom_range(199, 2);
			u = $urandom_range(1999998) - 999999;
			t = $urandom_range(999999);
			if (k == 0) u0 = u;
			if (k == 0) t0 = t;
			cmd(3'h1, {16'h0, ix[7:0], c[7:0]}, u, t, 0);
			cmd(3'h2, {16'h0, ix[7:0], c[7:0]}, 0, 0, 0);
			rd(cdcp_pkg::A_REP0, {OK, u});
			rd(cdcp_pkg::A_REP1, {OK, t});
		end
		foreach (bad[i]) cmd(3'h1, {16'h0, bad[i]}, 32'h1, 32'h1, 1);
		cmd(3'h2, 32'h013C, 0, 0, 1);
		cmd(3'h2, 32'h0115, 0, 0, 0);
		rd(cdcp_pkg::A_REP0, {OK, u0});
		rd(cdcp_pkg::A_REP1, {OK, t0});
		cmd(3'h2, 32'h0101, 0, 0, 0);
		rd(cdcp_pkg::A_REP0, {OK, 32'h0});
		$display("test curve_points done");
		cmd(3'h4, 32'h0102, 0, 0, 0);
		cmd(3'h4, 32'h0105, 0, 0, 0);
		cmp(34'(diode_exc), 34'h9);
		cmd(3'h4, 32'h0005, 0, 0, 0);
		cmd(3'h4, 32'h0101, 0, 0, 1);
		cmd(3'h4, 32'h0106, 0, 0, 1);
		cmd(3'h4, 32'h0202, 0, 0, 1);
		cmp(34'(diode_exc), 34'h1);
		cmd(3'h7, 32'h0205, 0, 0, 0);
		cmp(34'(diode_exc), 34'h0);
		cmp(34'(sensor_type), 34'h11121111);
		cmd(3'h4, 32'h0102, 0, 0, 1);
		cmp(34'(diode_exc), 34'h0);
		cmd(3'h7, 32'h0209, 0, 0, 1);
		cmd(3'h7, 32'h0506, 0, 0, 1);
		cmd(3'h4, 32'h0103, 0, 0, 0);
		rd(cdcp_pkg::A_EXC, {OK, 32'h2});
		rd(cdcp_pkg::A_TYPE, {OK, 32'h11121111});
		$display("test excitation done");
		ei = 32'h0;
		eu = 24'h249249;
		for (k = 0; k < 9; k++) begin
			f = k % 8;
			un = k % 5 + 1;
			ei[4*f +: 4] = 4'(k);
			eu[3*f +: 3] = 3'(un);
			cmd(3'h5, {8'h0, 8'(un), 8'(k), 8'(f + 1)}, 0, 0, 0);
		end
		for (k = 1; k <= 8; k++) begin
			cmd(3'h6, k, 0, 0, 0);
			rd(cdcp_pkg::A_REP0, {OK, 28'h0, ei[4*(k-1) +: 4]});
			rd(cdcp_pkg::A_REP1, {OK, 29'h0, eu[3*(k-1) +: 3]});
		end
		foreach (badf[i]) cmd(3'h5, {8'h0, badf[i]}, 0, 0, 1);
		cmd(3'h6, 32'h9, 0, 0, 1);
		cmp(34'(field_item), 34'(ei));
		cmp(34'(field_units), 34'(eu));
		custom_mode <= 1'b0;
		pref_units  <= 24'($urandom());
		repeat (2) @(posedge mclk);
		cmp(34'(field_item), 34'h87654321);
		cmp(34'(field_units), 34'(pref_units));
		custom_mode <= 1'b1;
		$display("test display_fields done");
		cmd(3'h3, 32'h62, 0, 0, 1);
		cmp(34'(pulses), 34'h0);
		cmd(3'h3, 32'h63, 0, 0, 0);
		cmp(34'(pulses), 34'h1);
		cmp(34'(diode_exc), 34'h0);
		cmp(34'(sensor_type), 34'h11111111);
		cmp(34'(field_item), 34'h0);
		cmp(34'(field_units), 34'h249249);
		$display("test factory_restore done");
		results();
	end
endmodule
`default_nettype wire
